// file: rtl/acsc_pkg.sv
package acsc_pkg;
  // operating modes of the converter path
  typedef enum logic [1:0]
  {
    ACSC_M3  = 2'b00,  // three inputs, synchronous pixel sampling
    ACSC_M2  = 2'b01,  // even/odd inputs, synchronous
    ACSC_M1A = 2'b10,  // one input, coefficient sets per line
    ACSC_M1B = 2'b11   // one input per line, inputs sequenced
  } acsc_mode_e;

  // channel codes
  localparam logic [1:0] CH_RED   = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE  = 2'h2;

  // input clock multiplier codes
  localparam logic [1:0] MUL_X1 = 2'h1;
  localparam logic [1:0] MUL_X2 = 2'h2;
  localparam logic [1:0] MUL_X3 = 2'h3;

  // offset correction word, signed plus or minus nine bits
  localparam int              OFS_W   = 10;
  localparam logic [OFS_W-1:0] OFS_MAX = 10'h1FF;
  localparam logic [OFS_W-1:0] OFS_MIN = 10'h201;
  localparam logic [OFS_W-1:0] OFS_RST = 10'h000;

  localparam int         CNT_W    = 16;      // pixel delay / width counters
  localparam int         ADC_W    = 16;      // converter word
  localparam logic [2:0] SETS_MAX = 3'h5;    // coefficient sets in mode 1a
  localparam logic [2:0] INPUTS_1B_LAST = 3'h2; // three inputs, then loop

  // negative clock pin low this many cycles means single-ended clock
  localparam logic [7:0] DET_LOW_CYC = 8'h40;

  // configuration as written by software
  typedef struct packed
  {
    acsc_mode_e            mode;       // operating mode
    logic                  clk_pixel;  // 1 pixel-rate clock, 0 converter-rate
    logic [2:0][1:0]       order;      // programmed channel order
    logic [1:0]            sel_1a;     // single input in mode 1a
    logic [2:0]            num_sets;   // coefficient sets used in mode 1a
    logic [CNT_W-1:0]      clamp_dly;  // pixels from sync to clamp start
    logic [CNT_W-1:0]      clamp_wid;  // clamp length in pixels
    logic                  gate_en;    // gate clamp with sample clock
    logic [2:0]            auto_blk;   // automatic black loop per channel
  } acsc_cfg_s;
endpackage

// file: rtl/acsc_top.sv
`timescale 1ns/1ps
module acsc_top
  import acsc_pkg::*;
(
  input  wire logic                     i_clk_sys,         // converter-rate clock
  input  wire logic                     i_nrst,            // sync reset, active low
  input  wire acsc_cfg_s                i_cfg,             // software configuration
  input  wire logic                     i_line_sync_pulse, // line sync pin
  input  wire logic                     i_clk_neg_pin,     // negative clock pin level
  input  wire logic                     i_sample_clk,      // internal sample phase
  input  wire logic                     i_adc_valid,       // converter word valid
  input  wire logic signed [ADC_W-1:0]  i_adc_data,        // converter word
  input  wire logic signed [ADC_W-1:0]  i_blk_target,      // black level target
  input  wire logic [2:0][OFS_W-1:0]    i_ofs_manual,      // software offsets
  output logic [1:0]                    o_clk_mult,        // clock multiplier code
  output logic                          o_clk_is_diff,     // differential clock seen
  output logic [1:0]                    o_ch_sel,          // input fed to converter
  output logic [2:0]                    o_coef_sel,        // offset/gain set in use
  output logic                          o_input_clamp_pulse, // clamp switch drive
  output logic                          o_gated_clamp_pulse, // clamp AND sample
  output logic [2:0][OFS_W-1:0]         o_ofs_word         // offset word per channel
);

  logic             sync_m_r;    // first synchroniser stage
  logic             sync_s_r;    // second synchroniser stage
  logic             sync_d_r;    // delayed copy for edge detect
  logic             neg_m_r;     // first stage, negative clock pin
  logic             neg_s_r;     // second stage, negative clock pin
  logic [7:0]       low_cnt_r;   // cycles the negative pin stayed low
  acsc_mode_e       mode_r;      // mode seen last cycle
  logic [1:0]       ph_r;        // converter slot within a pixel
  logic [1:0]       ph_last;     // last slot index for the mode
  logic [2:0]       line_r;      // line sequence index
  logic             first_r;     // next sync restarts the sequence
  logic [CNT_W-1:0] pix_cnt_r;   // pixels since line sync
  logic [CNT_W:0]   clamp_end;   // first pixel past the clamp
  logic             clamp_on;    // clamp window active
  logic             sync_pulse;  // one-cycle detected line sync
  logic             mode_chg;    // mode differs from last cycle
  logic             pix_tick;    // last slot of a pixel
  logic [2:0]       line_last;   // wrap point of the line index
  logic [1:0]       ch_nxt;      // channel for the coming cycle
  logic [2:0]       coef_nxt;    // coefficient set for the coming cycle

  // line sync comes from the pin: two flops, then edge detect on the second
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end
    else
    begin
      sync_m_r <= i_line_sync_pulse;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end

  assign sync_pulse = sync_s_r & ~sync_d_r;
  assign mode_chg   = (mode_r != i_cfg.mode);

  // multiplier follows mode and clock type
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_clk_mult <= MUL_X1;
    end
    else if (!i_cfg.clk_pixel)
    begin
      o_clk_mult <= MUL_X1;   // converter-rate clock used as is
    end
    else
    begin
      case (i_cfg.mode)
        ACSC_M3: o_clk_mult <= MUL_X3;
        ACSC_M2: o_clk_mult <= MUL_X2;
        default: o_clk_mult <= MUL_X1; // mode one ignores the type bit
      endcase
    end
  end

  // clock format detect: a single-ended clock grounds the negative pin,
  // so a long low run there means single-ended; any high means a pair
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      neg_m_r       <= 1'b0;
      neg_s_r       <= 1'b0;
      low_cnt_r     <= 8'h00;
      o_clk_is_diff <= 1'b0;
    end
    else
    begin
      neg_m_r <= i_clk_neg_pin;
      neg_s_r <= neg_m_r;
      if (neg_s_r)
      begin
        low_cnt_r     <= 8'h00;
        o_clk_is_diff <= 1'b1;
      end
      else if (low_cnt_r == DET_LOW_CYC)
      begin
        o_clk_is_diff <= 1'b0;
      end
      else
      begin
        low_cnt_r <= low_cnt_r + 8'h01;
      end
    end
  end

  // slots per pixel: three, two or one converter cycles
  always_comb
  begin
    case (i_cfg.mode)
      ACSC_M3: ph_last = 2'h2;
      ACSC_M2: ph_last = 2'h1;
      default: ph_last = 2'h0;
    endcase
  end

  assign pix_tick = (ph_r >= ph_last);

  // slot counter; sync realigns it so the first pixel after sync starts
  // at slot zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      ph_r <= 2'h0;
    end
    else if (sync_pulse || mode_chg || pix_tick)
    begin
      ph_r <= 2'h0;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
    end
  end

  // wrap point of line sequencing; zero sets is treated as one
  always_comb
  begin
    if (i_cfg.mode == ACSC_M1B)
    begin
      line_last = INPUTS_1B_LAST;
    end
    else if (i_cfg.num_sets == 3'h0)
    begin
      line_last = 3'h0;
    end
    else if (i_cfg.num_sets > SETS_MAX)
    begin
      line_last = SETS_MAX - 3'h1;   // at most five sets
    end
    else
    begin
      line_last = i_cfg.num_sets - 3'h1;
    end
  end

  // line sequencing: mode change rearms, first sync picks entry zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      mode_r  <= ACSC_M3;
      line_r  <= 3'h0;
      first_r <= 1'b1;
    end
    else
    begin
      mode_r <= i_cfg.mode;
      if (mode_chg)
      begin
        line_r  <= 3'h0;
        first_r <= 1'b1;
      end
      else if (sync_pulse)
      begin
        first_r <= 1'b0;
        if (first_r || line_r >= line_last)
        begin
          line_r <= 3'h0;
        end
        else
        begin
          line_r <= line_r + 3'h1;
        end
      end
    end
  end

  // channel and coefficient choice per mode
  always_comb
  begin
    ch_nxt   = CH_RED;
    coef_nxt = 3'h0;
    case (i_cfg.mode)
      ACSC_M3:
      begin
        ch_nxt   = i_cfg.order[ph_r];
        coef_nxt = {1'b0, ch_nxt};
      end
      ACSC_M2:
      begin
        ch_nxt   = (ph_r == 2'h0) ? CH_BLUE : CH_GREEN;
        coef_nxt = {1'b0, ch_nxt};
      end
      ACSC_M1A:
      begin
        ch_nxt   = i_cfg.sel_1a;
        coef_nxt = line_r;         // coefficient set of the current line
      end
      ACSC_M1B:
      begin
        ch_nxt   = i_cfg.order[line_r[1:0]];
        coef_nxt = {1'b0, ch_nxt};             // input keeps own settings
      end
      default:
      begin
        ch_nxt   = CH_RED;
        coef_nxt = 3'h0;
      end
    endcase
  end

  // registered selects; one cycle behind the slot counter
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_ch_sel   <= CH_RED;
      o_coef_sel <= 3'h0;
    end
    else
    begin
      o_ch_sel   <= ch_nxt;
      o_coef_sel <= coef_nxt;
    end
  end

  // pixels since sync, held at the top rather than wrapping so a long
  // line can never retrigger the clamp
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      pix_cnt_r <= '1;
    end
    else if (sync_pulse)
    begin
      pix_cnt_r <= '0;
    end
    else if (pix_tick && pix_cnt_r != '1)
    begin
      pix_cnt_r <= pix_cnt_r + 1'b1;
    end
  end

  assign clamp_end = {1'b0, i_cfg.clamp_dly} + {1'b0, i_cfg.clamp_wid};
  assign clamp_on  = (pix_cnt_r >= i_cfg.clamp_dly) &&
                     ({1'b0, pix_cnt_r} < clamp_end);

  // clamp drives the switch to the bias reference over black pixels
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_input_clamp_pulse <= 1'b0;
      o_gated_clamp_pulse <= 1'b0;
    end
    else
    begin
      o_input_clamp_pulse <= clamp_on;
      // gating keeps the reset noise peak out of the clamp
      o_gated_clamp_pulse <= clamp_on & (i_sample_clk | ~i_cfg.gate_en);
    end
  end

  // black level loop per channel; auto steps one code per black sample,
  // slow but never overshoots on a noisy black row
  for (genvar c = 0; c < 3; c++)
  begin : g_blk
    always_ff @(posedge i_clk_sys)
    begin
      if (!i_nrst)
      begin
        o_ofs_word[c] <= OFS_RST;
      end
      else if (!i_cfg.auto_blk[c])
      begin
        o_ofs_word[c] <= i_ofs_manual[c];
      end
      else if (clamp_on && i_adc_valid && o_ch_sel == 2'(c))
      begin
        if (i_adc_data > i_blk_target && o_ofs_word[c] != OFS_MIN)
        begin
          o_ofs_word[c] <= o_ofs_word[c] - 10'h001;
        end
        else if (i_adc_data < i_blk_target && o_ofs_word[c] != OFS_MAX)
        begin
          o_ofs_word[c] <= o_ofs_word[c] + 10'h001;
        end
      end
    end
  end

endmodule

// file: sim/acsc_sensor.sv
`timescale 1ns/1ps
// sensor and timing host seen from the block's pins
module acsc_sensor
(
  input  wire logic i_clk_sys, // same clock as the block
  input  wire logic i_go,      // start a line
  input  wire logic i_diff,    // 1 differential pair, 0 single-ended
  output logic      o_sync,    // line sync pin
  output logic      o_neg,     // negative clock pin level
  output logic      o_smp      // sample phase
);
  logic [2:0] t_r   = 3'h0; // free phase counter
  logic [1:0] len_r = 2'h0; // sync cycles left
  // clock never stops, so writes always land
  always_ff @(posedge i_clk_sys)
    t_r <= t_r + 3'h1;
  assign o_smp = t_r[0];
  // single-ended means the pin is grounded
  assign o_neg = i_diff & ~t_r[0];
  // three cycles wide so the synchroniser cannot miss it
  always_ff @(posedge i_clk_sys)
    if (i_go)
      len_r <= 2'h3;
    else if (len_r != 2'h0)
      len_r <= len_r - 2'h1;
  assign o_sync = len_r != 2'h0;
endmodule

// file: sim/acsc_chk.sv
`timescale 1ns/1ps
// watches clock setup, sequencing, clamp and offsets at the ports
module acsc_chk
  import acsc_pkg::*;
(
  input wire logic                  i_clk_sys,           // clock
  input wire logic                  i_nrst,              // reset, active low
  input wire acsc_cfg_s             i_cfg,               // configuration
  input wire logic                  i_sample_clk,        // sample phase
  input wire logic [2:0][OFS_W-1:0] i_ofs_manual,        // software offsets
  input wire logic [1:0]            o_clk_mult,          // multiplier code
  input wire logic [1:0]            o_ch_sel,            // input fed
  input wire logic [2:0]            o_coef_sel,          // set in use
  input wire logic                  o_input_clamp_pulse, // clamp
  input wire logic                  o_gated_clamp_pulse, // gated clamp
  input wire logic [2:0][OFS_W-1:0] o_ofs_word           // offsets
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_mult_three: assert property (
    (i_cfg.mode == ACSC_M3 && i_cfg.clk_pixel) [*2] |-> o_clk_mult == MUL_X3)
    else $error("multiplier not three");
  a_mult_two: assert property (
    (i_cfg.mode == ACSC_M2 && i_cfg.clk_pixel) [*2] |-> o_clk_mult == MUL_X2)
    else $error("multiplier not two");
  a_mult_one: assert property (
    (i_cfg.mode[1] || !i_cfg.clk_pixel) [*2] |-> o_clk_mult == MUL_X1)
    else $error("multiplier not one");
  a_gate_and: assert property (
    o_input_clamp_pulse |-> o_gated_clamp_pulse == ($past(i_sample_clk) || !$past(i_cfg.gate_en)))
    else $error("gated clamp wrong");
  a_gate_in: assert property (
    o_gated_clamp_pulse |-> o_input_clamp_pulse)
    else $error("gated clamp outside clamp");
  a_ofs_manual: assert property (
    (!i_cfg.auto_blk[2] && $stable(i_ofs_manual[2])) [*2] |-> o_ofs_word[2] == i_ofs_manual[2])
    else $error("manual offset not applied");
  a_ofs_step: assert property (
    i_cfg.auto_blk[1] [*3] |-> (o_ofs_word[1] - $past(o_ofs_word[1])) inside {10'h000, 10'h001, 10'h3FF})
    else $error("auto offset jumped");
  a_ofs_range: assert property (
    o_ofs_word[0] != 10'h200 && o_ofs_word[1] != 10'h200 && o_ofs_word[2] != 10'h200)
    else $error("offset beyond nine bits");
  a_sel_range: assert property (
    o_coef_sel < SETS_MAX && o_ch_sel != 2'h3)
    else $error("select out of range");
  a_m2_pair: assert property (
    (i_cfg.mode == ACSC_M2) [*8] |-> o_ch_sel == CH_BLUE || o_ch_sel == CH_GREEN)
    else $error("mode two input wrong");
endmodule
bind acsc_top acsc_chk chk_i (.i_clk_sys, .i_nrst, .i_cfg, .i_sample_clk, .i_ofs_manual,
  .o_clk_mult, .o_ch_sel, .o_coef_sel, .o_input_clamp_pulse, .o_gated_clamp_pulse, .o_ofs_word);

// file: sim/acsc_top_bench.sv
`timescale 1ns/1ps
// self-checking bench: sequencing, clamp timing, offsets, clock format
module acsc_top_bench;
  import acsc_pkg::*;
  logic                    i_clk_sys = 1'b0; // 125 MHz
  logic                    i_nrst = 1'b0;    // reset, active low
  acsc_cfg_s               cfg = '0;         // configuration under test
  logic                    go = 1'b0;        // start a line
  logic                    diff = 1'b1;      // clock format
  logic                    vld = 1'b0;       // converter word valid
  logic signed [ADC_W-1:0] dat = '0;         // converter word
  logic signed [ADC_W-1:0] tgt = '0;         // black target
  logic [2:0][OFS_W-1:0]   man = '0;         // manual offsets
  logic                    sync, neg, smp, clp, gclp, isd;
  logic [1:0]              mult, ch, ord[3];
  logic [1:0]              q[$];             // captured input selects
  logic [2:0]              coef;
  logic [2:0][OFS_W-1:0]   ofs;
  logic [2:0]              nst[4] = '{3'h5, 3'h2, 3'h7, 3'h0};
  acsc_mode_e              cm[3] = '{ACSC_M3, ACSC_M2, ACSC_M1B};
  logic [31:0]             rs = 32'h56;      // xorshift state
  int failures = 0, comparisons = 0, cyc = 0, e, n, s0, s1;
  acsc_top dut (.i_clk_sys, .i_nrst, .i_cfg(cfg), .i_line_sync_pulse(sync),
    .i_clk_neg_pin(neg), .i_sample_clk(smp), .i_adc_valid(vld), .i_adc_data(dat),
    .i_blk_target(tgt), .i_ofs_manual(man), .o_clk_mult(mult), .o_clk_is_diff(isd),
    .o_ch_sel(ch), .o_coef_sel(coef), .o_input_clamp_pulse(clp),
    .o_gated_clamp_pulse(gclp), .o_ofs_word(ofs));
  acsc_sensor host (.i_clk_sys, .i_go(go), .i_diff(diff), .o_sync(sync), .o_neg(neg),
    .o_smp(smp));
  initial
    forever #4 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // compare a design value with the model
  task automatic chk(input logic [9:0] g, input logic [9:0] x);
    comparisons++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask
  // compare a measured cycle count
  task automatic chk_n(input int g, input int x);
    chk(10'(g), 10'(x));
  endtask
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, about twice the expected run
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge i_clk_sys);
  endtask
  // one line: sync pulse, then let the selects settle
  task automatic line();
    step(1);
    go <= 1'b1;
    step(1);
    go <= 1'b0;
    step(12);
    #1;
  endtask
  // leave the mode briefly so the sequencing restarts
  task automatic setmode(input acsc_mode_e m);
    step(1);
    cfg.mode <= acsc_mode_e'(~m);
    step(3);
    cfg.mode <= m;
    step(3);
  endtask
  // random channel order, random clock type
  task automatic perm();
    rs = xs(rs);
    ord[0] = 2'(rs % 3);
    ord[1] = 2'((ord[0] + 1 + rs[4]) % 3);
    ord[2] = 2'(3 - ord[0] - ord[1]);
    step(1);
    cfg.order <= {ord[2], ord[1], ord[0]};
    cfg.clk_pixel <= rs[8];
  endtask
  // start of clamp from the line request, and its length
  task automatic meas(output int st, output int cnt);
    st = -1;
    cnt = 0;
    step(1);
    go <= 1'b1;
    for (int i = 0; i < 90; i++)
    begin
      step(1);
      go <= 1'b0;
      #1;
      if (clp === 1'b1)
      begin
        if (st < 0)
          st = i;
        cnt++;
      end
    end
  endtask
  initial
  begin
    step(3);
    i_nrst <= 1'b1;
    // synchronous modes: slot order and multiplier
    for (int m = 0; m < 2; m++)
    begin
      perm();
      setmode(acsc_mode_e'(m));
      line();
      chk(10'(mult), rs[8] ? 10'(3 - m) : 10'(MUL_X1));
      q = {};
      repeat (6)
      begin
        q.push_back(ch);
        step(1);
        #1;
      end
      // thirteen edges after the request the select shows the slot eight slots past sync, one behind the slot counter
      chk(10'(q[0]), 10'(m ? CH_BLUE : ord[2]));
      for (int i = 0; i < 5; i++)
        chk(10'(q[i + 1]), 10'(m ? (q[i] == CH_BLUE ? CH_GREEN : CH_BLUE)
          : ord[q[i] == ord[0] ? 1 : q[i] == ord[1] ? 2 : 0]));
      // flip the clock type so both multiplier branches are seen in both synchronous modes
      step(1);
      cfg.clk_pixel <= !rs[8];
      step(2);
      #1;
      chk(10'(mult), !rs[8] ? 10'(3 - m) : 10'(MUL_X1));
    end
    $display("test synchronous modes done");
    // mode 1b: one input per line, looping after the third
    perm();
    setmode(ACSC_M1B);
    for (int k = 0; k < 7; k++)
    begin
      line();
      chk(10'(ch), 10'(ord[k % 3]));
      chk(10'(coef), 10'(ord[k % 3]));
    end
    chk(10'(mult), 10'(MUL_X1));
    $display("test line sequencing done");
    // mode 1a: coefficient sets, counts at and beyond the limits
    for (int i = 0; i < 4; i++)
    begin
      step(1);
      cfg.num_sets <= nst[i];
      cfg.sel_1a <= 2'(i % 3);
      setmode(ACSC_M1A);
      e = nst[i] == 0 ? 1 : nst[i] > 5 ? 5 : nst[i];
      for (int k = 0; k < 6; k++)
      begin
        line();
        chk(10'(coef), 10'(k % e));
        chk(10'(ch), 10'(i % 3));
      end
    end
    $display("test coefficient sets done");
    // clamp delay and width in pixels of 3, 2 and 1 cycles
    for (int m = 0; m < 3; m++)
    begin
      step(1);
      cfg.gate_en <= (m == 2) ? rs[m] : !m[0]; // gating on, then off, then random
      cfg.clamp_wid <= 16'h0004;
      cfg.clamp_dly <= 16'h0002;
      setmode(cm[m]);
      meas(s0, n);
      chk_n(n, 4 * (3 - m));
      step(1);
      cfg.clamp_dly <= 16'h0005;
      meas(s1, n);
      chk_n(s1 - s0, 3 * (3 - m));
    end
    step(1);
    cfg.clamp_wid <= 16'h0000;
    meas(s0, n);
    chk_n(n, 0);
    $display("test clamp timing done");
    // green runs the automatic loop with data above target
    step(1);
    for (int j = 0; j < 3; j++)
    begin
      rs = xs(rs);
      man[j] <= rs[9:0] == 10'h200 ? OFS_MIN : rs[9:0];
    end
    cfg.auto_blk <= 3'h2;
    cfg.sel_1a <= CH_GREEN;
    cfg.clamp_dly <= 16'h0001;
    cfg.clamp_wid <= 16'h02BC;
    vld <= 1'b1;
    tgt <= 16'h0100;
    dat <= 16'h0300;
    setmode(ACSC_M1A);
    line();
    step(750);
    #1;
    chk(ofs[1], OFS_MIN);
    chk(ofs[0], man[0]);
    chk(ofs[2], man[2]);
    $display("test black loop done");
    // clock format sensed from the negative pin
    step(1);
    diff <= 1'b0;
    step(100);
    #1;
    chk(10'(isd), 10'h000);
    step(1);
    diff <= 1'b1;
    step(100);
    #1;
    chk(10'(isd), 10'h001);
    $display("test clock format done");
    finish_test();
  end
endmodule
